//--- verilog/omx_pkg.sv
// Package for the OR, move and bank instruction execution block.
// Assumes a single 25 MHz core clock and an AXI4-Lite register master.
package omx_pkg;

    // Register byte offsets on the AXI4-Lite bus
    localparam logic [5:0] OFS_INSTR    = 6'h00;
    localparam logic [5:0] OFS_STATUS   = 6'h04;
    localparam logic [5:0] OFS_ACC      = 6'h08;
    localparam logic [5:0] OFS_BANK     = 6'h0C;
    localparam logic [5:0] OFS_PTR0     = 6'h10;
    localparam logic [5:0] OFS_PTR1     = 6'h14;
    localparam logic [5:0] OFS_PTR2     = 6'h18;
    localparam logic [5:0] OFS_CTRL     = 6'h1C;
    localparam logic [5:0] OFS_MEM_ADDR = 6'h20;
    localparam logic [5:0] OFS_MEM_DATA = 6'h24;

    // Status and control field positions
    localparam int STS_BUSY  = 0;
    localparam int STS_WAIT2 = 1;
    localparam int STS_NEG   = 2;
    localparam int STS_ZERO  = 3;
    localparam int CTRL_EXT  = 0;

    // Reset values
    localparam logic [7:0]  RST_ACC  = 8'h00;
    localparam logic [7:0]  RST_BANK = 8'h00;
    localparam logic [11:0] RST_PTR  = 12'h000;

    // Data space constants
    localparam logic [11:0] ACC_ADDR      = 12'hFE8;
    localparam logic [7:0]  ACCESS_SPLIT  = 8'h60;
    localparam logic [7:0]  INDEX_LIMIT   = 8'h5F;
    localparam logic [3:0]  ACCESS_HI_BNK = 4'hF;
    localparam logic [3:0]  BANK_MASK_HI  = 4'h0;

    // Opcode match values
    localparam logic [7:0] OPC_OR_IMM   = 8'h09;
    localparam logic [5:0] OPC_OR_FILE  = 6'h04;
    localparam logic [5:0] OPC_FMOVE    = 6'h14;
    localparam logic [7:0] OPC_PTR_LOAD = 8'hEE;
    localparam logic [3:0] OPC_M2M      = 4'hC;
    localparam logic [7:0] OPC_BANK_LD  = 8'h01;

    // Decoded operation codes
    localparam logic [2:0] OP_NONE   = 3'h0;
    localparam logic [2:0] OP_OR_IMM = 3'h1;
    localparam logic [2:0] OP_OR_F   = 3'h2;
    localparam logic [2:0] OP_FMOVE  = 3'h3;
    localparam logic [2:0] OP_PLOAD  = 3'h4;
    localparam logic [2:0] OP_M2M    = 3'h5;
    localparam logic [2:0] OP_BANK   = 3'h6;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Execution states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_Q1    = 6'h02,
        ST_Q2    = 6'h04,
        ST_Q3    = 6'h08,
        ST_Q4    = 6'h10,
        ST_WAIT2 = 6'h20
    } omx_state_e;

endpackage : omx_pkg

//--- verilog/omx_exec.sv
// Execution block for OR, move, pointer load and bank select load.
// Assumes an AXI4-Lite master on SYS_CLK; instruction words are written
// to the instruction register, data memory is held inside the block.
// Notes on behaviour
// - OR immediate ORs accumulator with low-byte literal into accumulator.
// - OR and file move update only negative and zero flags.
// - OR with file: d=0 writes accumulator, d=1 writes file register.
// - Omitted destination and access operands both default to one.
// - Access bit 0 uses access bank; 1 joins field with bank select.
// - Extended mode, access 0, field up to 95 uses indexed offset.
// - Pointer load: two words, high bits first cycle, low byte second.
// - File move copies file to accumulator or back to itself.
// - Eight-bit field reaches any byte of a 256-byte bank.
// - Memory move: read source first cycle, write destination last quarter.
// - Memory move may use accumulator as source or destination.
// - Bank select load forces upper four bits of bank select to zero.
// - Pointer load, memory move, bank load leave flags unchanged.
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module omx_exec (
    input  wire logic        SYS_CLK,
    input  wire logic        NRST,
    input  wire logic [5:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [5:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY
);

    typedef struct packed {
        omx_pkg::omx_state_e st;
        logic                second;
        logic [15:0]         iw;
        logic [15:0]         iw2;
        logic [11:0]         addr;
        logic [7:0]          opnd;
        logic [7:0]          res;
        logic [7:0]          acc;
        logic                neg;
        logic                zero;
        logic [7:0]          bank;
        logic [2:0][11:0]    ptr;
        logic                ext;
        logic [11:0]         mem_addr;
        logic                aw_got;
        logic [5:0]          awaddr;
        logic                w_got;
        logic [31:0]         wdata;
        logic [3:0]          wstrb;
        logic                awready;
        logic                wready;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                arready;
        logic                rvalid;
        logic [31:0]         rdata;
        logic [1:0]          rresp;
    } omx_s;

    omx_s        s_q;
    omx_s        s_d;
    logic [7:0]  mem [0:4095];
    logic        mem_we;
    logic [11:0] mem_wa;
    logic [7:0]  mem_wd;

    // Opcode decode shared by every quarter
    function automatic logic [2:0] op_of(input logic [15:0] w);
        if (w[15:8] == omx_pkg::OPC_OR_IMM)
            return omx_pkg::OP_OR_IMM;
        if (w[15:10] == omx_pkg::OPC_OR_FILE)
            return omx_pkg::OP_OR_F;
        if (w[15:10] == omx_pkg::OPC_FMOVE)
            return omx_pkg::OP_FMOVE;
        if (w[15:8] == omx_pkg::OPC_PTR_LOAD && w[7:6] == 2'b00 &&
            w[5:4] != 2'b11)
            return omx_pkg::OP_PLOAD;
        if (w[15:12] == omx_pkg::OPC_M2M)
            return omx_pkg::OP_M2M;
        if (w[15:8] == omx_pkg::OPC_BANK_LD)
            return omx_pkg::OP_BANK;
        return omx_pkg::OP_NONE;
    endfunction : op_of

    // Effective address of a byte-oriented register field
    function automatic logic [11:0] file_addr(input logic [15:0] w,
                                              input logic        ext,
                                              input logic [7:0]  bank,
                                              input logic [11:0] p2);
        logic [7:0] f;
        f = w[7:0];
        if (w[8])
            return {bank[3:0], f};
        if (ext && f <= omx_pkg::INDEX_LIMIT)
            return p2 + {4'h0, f};
        if (f < omx_pkg::ACCESS_SPLIT)
            return {4'h0, f};
        return {omx_pkg::ACCESS_HI_BNK, f};
    endfunction : file_addr

    // Next state of execution engine and register slave
    always_comb begin
        logic [2:0]  op;
        logic        do_wr;
        logic        do_rd;
        logic        exec_free;
        logic [7:0]  rd_byte;
        do_wr     = 1'b0;
        do_rd     = 1'b0;
        s_d       = s_q;
        mem_we    = 1'b0;
        mem_wa    = s_q.addr;
        mem_wd    = s_q.res;
        op        = op_of(s_q.iw);
        rd_byte   = (s_q.addr == omx_pkg::ACC_ADDR) ? s_q.acc : mem[s_q.addr];
        exec_free = (s_q.st == omx_pkg::ST_IDLE) ||
                    (s_q.st == omx_pkg::ST_WAIT2);

        // Quarter-phase engine
        case (s_q.st)
            omx_pkg::ST_IDLE, omx_pkg::ST_WAIT2: s_d.st = s_q.st;
            omx_pkg::ST_Q1: begin
                if (s_q.second)
                    s_d.addr = s_q.iw2[11:0];
                else if (op == omx_pkg::OP_M2M)
                    s_d.addr = s_q.iw[11:0];
                else
                    s_d.addr = file_addr(s_q.iw, s_q.ext, s_q.bank,
                                         s_q.ptr[2]);
                s_d.st = omx_pkg::ST_Q2;
            end
            omx_pkg::ST_Q2: begin
                if (s_q.second) begin
                    if (op == omx_pkg::OP_PLOAD)
                        s_d.opnd = s_q.iw2[7:0];
                end else begin
                    case (op)
                        omx_pkg::OP_OR_F, omx_pkg::OP_FMOVE,
                        omx_pkg::OP_M2M:
                            s_d.opnd = rd_byte;
                        omx_pkg::OP_PLOAD:
                            s_d.opnd = {4'h0, s_q.iw[3:0]};
                        default:
                            s_d.opnd = s_q.iw[7:0];
                    endcase
                end
                s_d.st = omx_pkg::ST_Q3;
            end
            omx_pkg::ST_Q3: begin
                if (!s_q.second) begin
                    case (op)
                        omx_pkg::OP_OR_IMM, omx_pkg::OP_OR_F:
                            s_d.res = s_q.acc | s_q.opnd;
                        omx_pkg::OP_BANK:
                            s_d.res = {omx_pkg::BANK_MASK_HI,
                                       s_q.opnd[3:0]};
                        default:
                            s_d.res = s_q.opnd;
                    endcase
                end
                s_d.st = omx_pkg::ST_Q4;
            end
            omx_pkg::ST_Q4: begin
                s_d.st = omx_pkg::ST_IDLE;
                if (s_q.second) begin
                    if (op == omx_pkg::OP_PLOAD) begin
                        s_d.ptr[s_q.iw[5:4]][7:0] = s_q.opnd;
                    end else if (op == omx_pkg::OP_M2M) begin
                        if (s_q.addr == omx_pkg::ACC_ADDR)
                            s_d.acc = s_q.res;
                        else
                            mem_we = 1'b1;
                    end
                end else begin
                    case (op)
                        omx_pkg::OP_OR_IMM:
                            s_d.acc = s_q.res;
                        omx_pkg::OP_OR_F, omx_pkg::OP_FMOVE: begin
                            if (!s_q.iw[9] ||
                                s_q.addr == omx_pkg::ACC_ADDR)
                                s_d.acc = s_q.res;
                            else
                                mem_we = 1'b1;
                        end
                        omx_pkg::OP_PLOAD: begin
                            s_d.ptr[s_q.iw[5:4]][11:8] = s_q.res[3:0];
                            s_d.st = omx_pkg::ST_WAIT2;
                        end
                        omx_pkg::OP_M2M:
                            s_d.st = omx_pkg::ST_WAIT2;
                        omx_pkg::OP_BANK:
                            s_d.bank = s_q.res;
                        default: s_d.st = omx_pkg::ST_IDLE;
                    endcase
                    // Only N and Z move, and only for OR and file move
                    if (op == omx_pkg::OP_OR_IMM || op == omx_pkg::OP_OR_F ||
                        op == omx_pkg::OP_FMOVE) begin
                        s_d.neg  = s_q.res[7];
                        s_d.zero = (s_q.res == 8'h00);
                    end
                end
            end
            default: s_d.st = omx_pkg::ST_IDLE;
        endcase

        // Write address and data channels, taken in either order
        if (S_AXI_AWVALID && s_q.awready) begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && s_q.wready) begin
            s_d.w_got = 1'b1;
            s_d.wdata = S_AXI_WDATA;
            s_d.wstrb = S_AXI_WSTRB;
        end
        if (S_AXI_BREADY && s_q.bvalid)
            s_d.bvalid = 1'b0;

        // Register write, held off while an instruction is executing
        do_wr = s_q.aw_got && s_q.w_got && !s_q.bvalid && exec_free;
        if (do_wr) begin
            s_d.aw_got = 1'b0;
            s_d.w_got  = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = omx_pkg::RESP_OKAY;
            case (s_q.awaddr)
                omx_pkg::OFS_INSTR: begin
                    if (s_q.wstrb[1:0] == 2'b11) begin
                        if (s_q.st == omx_pkg::ST_WAIT2) begin
                            s_d.iw2    = s_q.wdata[15:0];
                            s_d.second = 1'b1;
                        end else begin
                            s_d.iw     = s_q.wdata[15:0];
                            s_d.second = 1'b0;
                        end
                        s_d.st = omx_pkg::ST_Q1;
                    end
                end
                omx_pkg::OFS_STATUS, omx_pkg::OFS_PTR0,
                omx_pkg::OFS_PTR1, omx_pkg::OFS_PTR2: ; // Read-only
                omx_pkg::OFS_ACC:
                    if (s_q.wstrb[0])
                        s_d.acc = s_q.wdata[7:0];
                omx_pkg::OFS_BANK:
                    if (s_q.wstrb[0])
                        s_d.bank = {omx_pkg::BANK_MASK_HI,
                                    s_q.wdata[3:0]};
                omx_pkg::OFS_CTRL:
                    if (s_q.wstrb[0])
                        s_d.ext = s_q.wdata[omx_pkg::CTRL_EXT];
                omx_pkg::OFS_MEM_ADDR:
                    if (s_q.wstrb[1:0] == 2'b11)
                        s_d.mem_addr = s_q.wdata[11:0];
                omx_pkg::OFS_MEM_DATA: begin
                    mem_we = s_q.wstrb[0];
                    mem_wa = s_q.mem_addr;
                    mem_wd = s_q.wdata[7:0];
                end
                default: s_d.bresp = omx_pkg::RESP_DECERR;
            endcase
        end
        s_d.awready = !s_d.aw_got && !s_d.bvalid;
        s_d.wready  = !s_d.w_got && !s_d.bvalid;

        // Read channel, answered one cycle after the address is taken
        if (S_AXI_RREADY && s_q.rvalid)
            s_d.rvalid = 1'b0;
        do_rd = S_AXI_ARVALID && s_q.arready;
        if (do_rd) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = omx_pkg::RESP_OKAY;
            s_d.rdata  = 32'h0000_0000;
            case (S_AXI_ARADDR)
                omx_pkg::OFS_INSTR:    s_d.rdata[15:0] = s_q.iw;
                omx_pkg::OFS_STATUS: begin
                    s_d.rdata[omx_pkg::STS_BUSY]  = !exec_free;
                    s_d.rdata[omx_pkg::STS_WAIT2] =
                        (s_q.st == omx_pkg::ST_WAIT2);
                    s_d.rdata[omx_pkg::STS_NEG]   = s_q.neg;
                    s_d.rdata[omx_pkg::STS_ZERO]  = s_q.zero;
                end
                omx_pkg::OFS_ACC:      s_d.rdata[7:0]  = s_q.acc;
                omx_pkg::OFS_BANK:     s_d.rdata[7:0]  = s_q.bank;
                omx_pkg::OFS_PTR0:     s_d.rdata[11:0] = s_q.ptr[0];
                omx_pkg::OFS_PTR1:     s_d.rdata[11:0] = s_q.ptr[1];
                omx_pkg::OFS_PTR2:     s_d.rdata[11:0] = s_q.ptr[2];
                omx_pkg::OFS_CTRL:
                    s_d.rdata[omx_pkg::CTRL_EXT] = s_q.ext;
                omx_pkg::OFS_MEM_ADDR: s_d.rdata[11:0] = s_q.mem_addr;
                omx_pkg::OFS_MEM_DATA: s_d.rdata[7:0]  = mem[s_q.mem_addr];
                default:               s_d.rresp = omx_pkg::RESP_DECERR;
            endcase
        end
        s_d.arready = !s_d.rvalid;
    end

    // State register
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            s_q          <= '0;
            s_q.st       <= omx_pkg::ST_IDLE;
            s_q.acc      <= omx_pkg::RST_ACC;
            s_q.bank     <= omx_pkg::RST_BANK;
            s_q.ptr      <= {3{omx_pkg::RST_PTR}};
        end else begin
            s_q <= s_d;
        end
    end

    // Data memory, 4096 bytes, no reset
    always_ff @(posedge SYS_CLK) begin
        if (mem_we)
            mem[mem_wa] <= mem_wd;
    end

    // Outputs straight from the state register
    assign S_AXI_AWREADY = s_q.awready;
    assign S_AXI_WREADY  = s_q.wready;
    assign S_AXI_BVALID  = s_q.bvalid;
    assign S_AXI_BRESP   = s_q.bresp;
    assign S_AXI_ARREADY = s_q.arready;
    assign S_AXI_RVALID  = s_q.rvalid;
    assign S_AXI_RDATA   = s_q.rdata;
    assign S_AXI_RRESP   = s_q.rresp;

endmodule : omx_exec

//--- verification/omx_exec_asserts.sv
// Bus-side checker for the OR, move and bank execution block.
// Assumes it is bound to omx_exec and sees only that module's ports.
`timescale 1ns/1ps
module omx_exec_asserts (
    input wire logic        SYS_CLK,
    input wire logic        NRST,
    input wire logic        S_AXI_AWREADY,
    input wire logic        S_AXI_WREADY,
    input wire logic [1:0]  S_AXI_BRESP,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic [5:0]  S_AXI_ARADDR,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0]  S_AXI_RRESP,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);

    // Read address taken at this edge
    logic rd_take;
    assign rd_take = S_AXI_ARVALID && S_AXI_ARREADY;

    // Handshake and answer timing
    property p_b_hold;
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response not held");
    property p_r_hold;
        S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read data not held");
    property p_ar_excl;
        S_AXI_RVALID |-> !S_AXI_ARREADY;
    endproperty
    a_ar_excl: assert property (p_ar_excl)
        else $error("read address ready during response");
    property p_aw_excl;
        S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY;
    endproperty
    a_aw_excl: assert property (p_aw_excl)
        else $error("write ready during response");
    property p_rd_ans;
        rd_take |=> S_AXI_RVALID ##1 (S_AXI_RVALID || $past(S_AXI_RREADY));
    endproperty
    a_rd_ans: assert property (p_rd_ans)
        else $error("read answer late or dropped");

    // Unmapped and narrow register reads
    property p_rd_decerr;
        rd_take && S_AXI_ARADDR > 6'h24 |=> S_AXI_RDATA == 32'h0000_0000
            && S_AXI_RRESP == omx_pkg::RESP_DECERR;
    endproperty
    a_rd_decerr: assert property (p_rd_decerr)
        else $error("unmapped read not refused");
    property p_bank_hi;
        rd_take && S_AXI_ARADDR == omx_pkg::OFS_BANK |=> S_AXI_RDATA[31:4] == 0;
    endproperty
    a_bank_hi: assert property (p_bank_hi)
        else $error("bank select upper bits set");
    property p_ptr_w;
        rd_take && S_AXI_ARADDR inside {6'h10, 6'h14, 6'h18}
            |=> S_AXI_RDATA[31:12] == 20'h0_0000;
    endproperty
    a_ptr_w: assert property (p_ptr_w)
        else $error("pointer wider than twelve bits");

    // Main scenarios reached
    c_decerr: cover property (rd_take && S_AXI_ARADDR > 6'h24);
    c_bank: cover property (rd_take && S_AXI_ARADDR == omx_pkg::OFS_BANK);
    c_wr: cover property (S_AXI_BVALID && S_AXI_BREADY);
endmodule : omx_exec_asserts

bind omx_exec omx_exec_asserts omx_exec_asserts_i (
    .SYS_CLK, .NRST, .S_AXI_AWREADY, .S_AXI_WREADY, .S_AXI_BRESP,
    .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID,
    .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY
);

//--- verification/omx_exec_tb_top.sv
// Testbench for the OR, move and bank execution block.
// Assumes omx_exec with its AXI4-Lite register map and a 25 MHz clock.
`timescale 1ns/1ps
module omx_exec_tb_top;
    logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [5:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, got;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, resp;
    int          fail_count, checked, i;

    // Clock, 40 ns period
    always #20 clk = ~clk;

    omx_exec omx_exec_i (.SYS_CLK(clk), .NRST(rst_n),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

    // Verdict and end of run
    task automatic test_done();
        if (fail_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done

    // Compare and count
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    // Bus write: address and data offered together, released when taken
    task automatic axi_wr(input logic [5:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        for (n = 0; n < 100 && bvalid !== 1'b1; n++) begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end
        if (n == 100) chk(32'h0000_0000, 32'hFFFF_FFFF);
        if (n == 100) test_done();
        resp = bresp;
        bready <= 1'b0;
    endtask : axi_wr

    // Bus read: address released when taken, ready held until the answer is sampled
    task automatic axi_rd(input logic [5:0] a);
        int n;
        @(posedge clk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        for (n = 0; n < 100 && rvalid !== 1'b1; n++) begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end
        if (n == 100) chk(32'h0000_0000, 32'hFFFF_FFFF);
        if (n == 100) test_done();
        got = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : axi_rd

    // Write a register expecting an OKAY answer, or read one and compare its data
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        axi_wr(a, d);
        chk({30'h0, resp}, {30'h0, omx_pkg::RESP_OKAY});
    endtask : wr
    task automatic rc(input logic [5:0] a, input logic [31:0] e);
        axi_rd(a);
        chk(got, e);
    endtask : rc

    // Issue one instruction word and wait until the engine is free
    task automatic run(input logic [15:0] w);
        int n;
        wr(omx_pkg::OFS_INSTR, {16'h0000, w});
        for (n = 0; n < 20; n++) begin
            axi_rd(omx_pkg::OFS_STATUS);
            if (got[omx_pkg::STS_BUSY] === 1'b0) break;
        end
        if (n == 20) chk(got, 32'h0000_0000);
        if (n == 20) test_done();
    endtask : run

    // Data memory access through the address window
    task automatic mw(input logic [11:0] a, input logic [7:0] d);
        wr(omx_pkg::OFS_MEM_ADDR, {20'h0_0000, a});
        wr(omx_pkg::OFS_MEM_DATA, {24'h00_0000, d});
    endtask : mw
    task automatic mc(input logic [11:0] a, input logic [7:0] e);
        wr(omx_pkg::OFS_MEM_ADDR, {20'h0_0000, a});
        rc(omx_pkg::OFS_MEM_DATA, {24'h00_0000, e});
    endtask : mc

    // Main sequence
    initial begin
        {clk, rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb, fail_count, checked} = '0;
        wstrb = 4'hF;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        // Data memory has no reset: clear the byte the window shows
        mw(12'h000, 8'h00);
        for (i = 0; i < 10; i++) rc(6'(i * 4), 32'h0000_0000);
        axi_wr(6'h30, 32'h0000_0001);
        chk({30'h0, resp}, {30'h0, omx_pkg::RESP_DECERR});
        axi_rd(6'h3C);
        chk({got[29:0], resp}, {30'h0, omx_pkg::RESP_DECERR});
        wr(omx_pkg::OFS_ACC, 32'h0000_009A);
        run(16'h0935);
        rc(omx_pkg::OFS_ACC, 32'h0000_00BF);
        rc(omx_pkg::OFS_STATUS, 32'h0000_0004);
        wr(omx_pkg::OFS_ACC, 32'h0000_0000);
        run(16'h0900);
        rc(omx_pkg::OFS_STATUS, 32'h0000_0008);
        run(16'h01F5);
        rc(omx_pkg::OFS_BANK, 32'h0000_0005);
        rc(omx_pkg::OFS_STATUS, 32'h0000_0008);
        mw(12'h5AB, 8'h13);
        wr(omx_pkg::OFS_ACC, 32'h0000_0091);
        run(16'h11AB);
        rc(omx_pkg::OFS_ACC, 32'h0000_0093);
        mc(12'h5AB, 8'h13);
        wr(omx_pkg::OFS_ACC, 32'h0000_0040);
        run(16'h13AB);
        mc(12'h5AB, 8'h53);
        rc(omx_pkg::OFS_STATUS, 32'h0000_0000);
        mw(12'h020, 8'h00);
        mw(12'hFA0, 8'h7E);
        run(16'h5020);
        rc(omx_pkg::OFS_STATUS, 32'h0000_0008);
        run(16'h50A0);
        rc(omx_pkg::OFS_ACC, 32'h0000_007E);
        run(16'h5220);
        rc(omx_pkg::OFS_ACC, 32'h0000_007E);
        rc(omx_pkg::OFS_STATUS, 32'h0000_0008);
        run(16'hEE23);
        rc(omx_pkg::OFS_STATUS, 32'h0000_000A);
        rc(omx_pkg::OFS_PTR2, 32'h0000_0300);
        run(16'hF0AB);
        rc(omx_pkg::OFS_PTR2, 32'h0000_03AB);
        run(16'hEE01);
        run(16'hF0FF);
        rc(omx_pkg::OFS_PTR0, 32'h0000_01FF);
        mw(12'h123, 8'hA5);
        run(16'hC123);
        run(16'hF456);
        mc(12'h456, 8'hA5);
        run(16'hC456);
        run(16'hFFE8);
        rc(omx_pkg::OFS_ACC, 32'h0000_00A5);
        wr(omx_pkg::OFS_ACC, 32'h0000_003C);
        run(16'hCFE8);
        run(16'hF789);
        mc(12'h789, 8'h3C);
        rc(omx_pkg::OFS_STATUS, 32'h0000_0008);
        wr(omx_pkg::OFS_CTRL, 32'h0000_0001);
        mw(12'h40A, 8'h55);
        mw(12'hF60, 8'h66);
        run(16'h505F);
        rc(omx_pkg::OFS_ACC, 32'h0000_0055);
        run(16'h5060);
        rc(omx_pkg::OFS_ACC, 32'h0000_0066);
        test_done();
    end
endmodule : omx_exec_tb_top
